//--- src/rue_top.v
// Remote upgrade error recovery: logs the reconfiguration cause and
// reloads the factory image, with an AHB-Lite register slave.
// Assumes the configuration engine signals crc and done on hclk, and that
// the two configuration pins are asynchronous and active low.
`include "rue_map.vh"
`timescale 1ns/1ps
`default_nettype none
module rue_top #(
  parameter WD_PRESCALE = `RUE_WD_PRESCALE,
  parameter PARAM_LAT   = `RUE_PARAM_LAT,
  parameter RELOAD_CYC  = `RUE_RELOAD_CYC
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        config_status_pin_n,
  input  wire        external_config_request_pin_n,
  input  wire        fabric_reconfig_request,
  input  wire        config_crc_error,
  input  wire        config_done,
  output reg         reconfig_start,
  output reg  [23:0] page_start_address,
  output reg         app_user_mode
);
  localparam [2:0] ST_FACT = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_APP  = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [4:0]  cause;
  reg  [23:0] app_page;
  reg  [23:0] wd_time;
  reg         wd_en;
  reg  [2:0]  prm_sel;
  reg         prm_busy;
  reg  [23:0] prm_data;
  reg  [7:0]  prm_cnt;
  reg         ext_q_d;
  reg  [7:0]  fab_cnt;
  reg         fab_done;
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg  [4:0]  next_cause;
  reg         start_pend;
  reg         kick;
  wire [1:0]  pin_q;
  wire        status_low;
  wire        ext_q;
  wire        ext_fall;
  wire        fab_event;
  wire        wd_expire;
  wire        wd_run;
  wire        addr_ok;
  wire        start_wr;
  wire        prm_wr;

  rue_sync #(
    .W       (2),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({config_status_pin_n, external_config_request_pin_n}),
    .q     (pin_q)
  );

  assign status_low = ~pin_q[1];
  assign ext_q      = pin_q[0];
  // A low pulse on the pin is taken at its falling edge
  assign ext_fall   = ext_q_d & ~ext_q;

  // The watchdog sees only app run time; leaving the app clears its count
  assign wd_run = wd_en & (state == ST_APP);

  rue_wdog #(
    .PRESCALE (WD_PRESCALE)
  ) u_wdog (
    .clk     (hclk),
    .rst_n   (hresetn),
    .run     (wd_run),
    .kick    (kick),
    .timeout (wd_time),
    .expire  (wd_expire)
  );

  // Reload request qualified only after the minimum hold time, which
  // filters short glitches from the fabric; one event per assertion.
  // Counting runs only in the app, so a request held across the load
  // is still honoured once the app is up instead of being used up early.
  assign fab_event = fabric_reconfig_request & ~fab_done &
                     (fab_cnt == RELOAD_CYC - 1);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fab_cnt  <= 8'h0;
      fab_done <= 1'b0;
      // Released pin level, so no false edge follows reset
      ext_q_d  <= 1'b1;
    end else begin
      ext_q_d <= ext_q;
      if (!fabric_reconfig_request || state != ST_APP) begin
        fab_cnt  <= 8'h0;
        fab_done <= 1'b0;
      end else if (fab_event) begin
        fab_done <= 1'b1;
      end else if (!fab_done) begin
        fab_cnt <= fab_cnt + 8'h1;
      end
    end
  end

  // Recovery cause, priority to the lowest bit so only one is ever set
  always @* begin
    next_cause = 5'h00;
    if (state == ST_LOAD) begin
      if (config_crc_error) begin
        next_cause = `RUE_CAUSE_CRC;
      end else if (status_low) begin
        next_cause = `RUE_CAUSE_STATUS;
      end
    end else if (state == ST_APP) begin
      if (fab_event) begin
        next_cause = `RUE_CAUSE_FABRIC;
      end else if (ext_fall) begin
        next_cause = `RUE_CAUSE_EXTCFG;
      end else if (wd_expire) begin
        next_cause = `RUE_CAUSE_WDOG;
      end
    end
  end

  // Loading ends on done or the first cause; the app ends only on a cause
  always @* begin
    case (state)
      ST_FACT: begin
        next_state = start_pend ? ST_LOAD : ST_FACT;
      end
      ST_LOAD: begin
        if (next_cause != 5'h00) begin
          next_state = ST_FACT;
        end else if (config_done) begin
          next_state = ST_APP;
        end else begin
          next_state = ST_LOAD;
        end
      end
      ST_APP: begin
        next_state = (next_cause != 5'h00) ? ST_FACT : ST_APP;
      end
      default: begin
        next_state = ST_FACT;
      end
    endcase
  end

  // No enable bit exists for recovery: it always restarts on a cause; crc and status are causes only while loading
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state              <= ST_FACT;
      cause              <= 5'h00;
      reconfig_start     <= 1'b0;
      page_start_address <= `RUE_FACTORY_PAGE;
      app_user_mode      <= 1'b0;
      start_pend         <= 1'b0;
    end else begin
      state          <= next_state;
      reconfig_start <= 1'b0;
      app_user_mode  <= (next_state == ST_APP);
      if (start_wr) begin
        start_pend <= 1'b1;
      end else if (state == ST_FACT) begin
        start_pend <= 1'b0;
      end
      if (next_cause != 5'h00) begin
        cause              <= next_cause;
        reconfig_start     <= 1'b1;
        page_start_address <= `RUE_FACTORY_PAGE;
      end else if (state == ST_FACT && start_pend) begin
        reconfig_start     <= 1'b1;
        page_start_address <= app_page;
      end
    end
  end

  // AHB-Lite slave, zero wait state, always OKAY
  // Only one slave, so hready is this block's own hreadyout
  assign addr_ok  = hsel & htrans[1] & hready;
  // Start is honoured only in the factory image; taking it later would
  // relaunch the app straight after a recovery and hide the fault.
  assign start_wr = wr_pend & (wr_addr == `RUE_OFS_CTRL) &
                    hwdata[`RUE_CTRL_START] & (state == ST_FACT);
  assign prm_wr   = wr_pend & (wr_addr == `RUE_OFS_PARAM_CMD);

  function [31:0] rd_mux;
    input [7:0] a;
    begin
      // Unmapped offsets read as zero
      case (a)
        `RUE_OFS_CTRL:      rd_mux = {30'h0, wd_en, start_pend};
        `RUE_OFS_APP_PAGE:  rd_mux = {8'h0, app_page};
        `RUE_OFS_WD_TIME:   rd_mux = {8'h0, wd_time};
        `RUE_OFS_PARAM_CMD: rd_mux = {23'h0, prm_busy, 5'h0, prm_sel};
        `RUE_OFS_PARAM_DAT: rd_mux = {8'h0, prm_data};
        `RUE_OFS_STATUS:    rd_mux = {21'h0, state, 3'h0, cause};
        default:            rd_mux = 32'h0;
      endcase
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h0;
      app_page  <= `RUE_APP_PAGE_RST;
      wd_time   <= `RUE_WD_TIME_RST;
      wd_en     <= 1'b0;
      kick      <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      kick      <= 1'b0;
      wr_pend   <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux(haddr[7:0]);
      end
      // Write data stands one cycle after its address phase
      if (wr_pend) begin
        case (wr_addr)
          `RUE_OFS_CTRL:     wd_en    <= hwdata[`RUE_CTRL_WD_EN];
          `RUE_OFS_APP_PAGE: app_page <= hwdata[23:0];
          `RUE_OFS_WD_TIME:  wd_time  <= hwdata[23:0];
          `RUE_OFS_WD_KICK:  kick     <= 1'b1;
          default:           kick     <= 1'b0;
        endcase
      end
    end
  end

  // Parameter read engine; commands while busy are dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prm_sel  <= 3'h0;
      prm_busy <= 1'b0;
      prm_data <= 24'h0;
      prm_cnt  <= 8'h0;
    end else begin
      if (prm_wr && !prm_busy) begin
        prm_sel  <= hwdata[2:0];
        prm_busy <= 1'b1;
        prm_cnt  <= 8'h0;
      end else if (prm_busy) begin
        if (prm_cnt == PARAM_LAT - 1) begin
          prm_busy <= 1'b0;
          // Readback data stands until the next completed read
          case (prm_sel)
            `RUE_PRM_SOURCE:   prm_data <= {19'h0, cause};
            `RUE_PRM_WD_TIME:  prm_data <= wd_time;
            `RUE_PRM_WD_EN:    prm_data <= {23'h0, wd_en};
            `RUE_PRM_APP_FLAG: prm_data <= {23'h0, state == ST_APP};
            default:           prm_data <= 24'h0;
          endcase
        end else begin
          prm_cnt <= prm_cnt + 8'h1;
        end
      end
    end
  end
endmodule // rue_top
`default_nettype wire

//--- inc/rue_map.vh
// Address map, cause codes, parameter codes and timing counts for the
// remote upgrade error recovery block.
// Assumes a 125 MHz bus clock and one 32-bit AHB-Lite slave port.
`ifndef RUE_MAP_VH
`define RUE_MAP_VH

// Register byte offsets
`define RUE_OFS_CTRL      8'h00
`define RUE_OFS_APP_PAGE  8'h04
`define RUE_OFS_WD_TIME   8'h08
`define RUE_OFS_WD_KICK   8'h0c
`define RUE_OFS_PARAM_CMD 8'h10
`define RUE_OFS_PARAM_DAT 8'h14
`define RUE_OFS_STATUS    8'h18

// Control register fields
`define RUE_CTRL_START    0
`define RUE_CTRL_WD_EN    1

// Parameter command and status fields
`define RUE_PCMD_BUSY     8
`define RUE_STAT_ST_LSB   8

// Cause codes, one bit per recovery source
`define RUE_CAUSE_CRC     5'h01
`define RUE_CAUSE_STATUS  5'h02
`define RUE_CAUSE_FABRIC  5'h04
`define RUE_CAUSE_EXTCFG  5'h08
`define RUE_CAUSE_WDOG    5'h10

// Parameter select codes for readback
`define RUE_PRM_WD_TIME   3'h2
`define RUE_PRM_WD_EN     3'h3
`define RUE_PRM_APP_FLAG  3'h5
`define RUE_PRM_SOURCE    3'h7

// Reset values and fixed addresses
`define RUE_FACTORY_PAGE  24'h000000
`define RUE_APP_PAGE_RST  24'h000000
`define RUE_WD_TIME_RST   24'h000000

// Timing
`define RUE_CLK_PERIOD_NS 8
`define RUE_RELOAD_REQ_NS 250
`define RUE_RELOAD_CYC \
  ((`RUE_RELOAD_REQ_NS + `RUE_CLK_PERIOD_NS - 1) / `RUE_CLK_PERIOD_NS)
`define RUE_PARAM_LAT     4
`define RUE_WD_PRESCALE   1024

`endif

//--- src/rue_sync.v
// Two flip-flop synchroniser for asynchronous pins.
// Assumes inputs are plain levels; the first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module rue_sync #(
  parameter W       = 1,
  parameter RST_VAL = 1'b1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{RST_VAL}};
      q    <= {W{RST_VAL}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // rue_sync
`default_nettype wire

//--- src/rue_wdog.v
// User watchdog: counts prescaled ticks while the application runs.
// Assumes run, kick and timeout come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rue_wdog #(
  parameter PRESCALE = 1024
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        run,
  input  wire        kick,
  input  wire [23:0] timeout,
  output reg         expire
);
  reg [31:0] pre;
  reg [23:0] cnt;
  wire       tick;

  // Divider gives a one-cycle enable, keeping a single clock
  assign tick = (pre == PRESCALE - 1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre    <= 32'h0;
      cnt    <= 24'h0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!run || kick) begin
        pre <= 32'h0;
        cnt <= 24'h0;
      end else begin
        pre <= tick ? 32'h0 : pre + 32'h1;
        if (tick) begin
          if (cnt >= timeout) begin
            expire <= 1'b1;
            cnt    <= 24'h0;
          end else begin
            cnt <= cnt + 24'h1;
          end
        end
      end
    end
  end
endmodule // rue_wdog
`default_nettype wire

//--- tb/rue_top_monitor.sv
// Checker for the error recovery block, bound to its top-level ports.
// Assumes one clock, hclk, and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rue_top_monitor #(
  parameter RELOAD_CYC = 32
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        external_config_request_pin_n,
  input wire logic        fabric_reconfig_request,
  input wire logic        config_done,
  input wire logic        reconfig_start,
  input wire logic [23:0] page_start_address,
  input wire logic        app_user_mode
);
  logic [7:0] fab_cnt;
  logic       img_on;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Run length of a held fabric request; a counter keeps long holds cheap
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      fab_cnt <= 8'h00;
    else if (fabric_reconfig_request && app_user_mode)
      fab_cnt <= fab_cnt + 8'h01;
    else
      fab_cnt <= 8'h00;
  end
  // Start pulses alternate between launching an image and leaving it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      img_on <= 1'b0;
    else if (reconfig_start)
      img_on <= !img_on;
  end
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus stall or error reply");
  property p_pulse; reconfig_start |=> !reconfig_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than 1");
  property p_page; reconfig_start && img_on |->
    page_start_address == 24'h000000; endproperty
  a_page: assert property (p_page) else $error("recovery not page 0");
  property p_leave; $fell(app_user_mode) |-> reconfig_start; endproperty
  a_leave: assert property (p_leave) else $error("app left, no restart");
  property p_enter; $rose(app_user_mode) |-> $past(config_done); endproperty
  a_enter: assert property (p_enter) else $error("app without done");
  property p_hold; !reconfig_start |-> $stable(page_start_address); endproperty
  a_hold: assert property (p_hold) else $error("page moved");
  property p_ext; $fell(external_config_request_pin_n) && app_user_mode
    |-> ##[1:5] !app_user_mode; endproperty
  a_ext: assert property (p_ext) else $error("pin request ignored");
  property p_fab; fab_cnt <= RELOAD_CYC + 3; endproperty
  a_fab: assert property (p_fab) else $error("fabric request ignored");
  property p_idle; reconfig_start |-> !app_user_mode; endproperty
  a_idle: assert property (p_idle) else $error("restart while in app");
endmodule // rue_top_monitor
bind rue_top rue_top_monitor #(.RELOAD_CYC(RELOAD_CYC)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .external_config_request_pin_n(external_config_request_pin_n),
  .fabric_reconfig_request(fabric_reconfig_request),
  .config_done(config_done), .reconfig_start(reconfig_start),
  .page_start_address(page_start_address), .app_user_mode(app_user_mode));
`default_nettype wire

//--- tb/rue_fab_model.sv
// Fabric-side user logic and board pins facing the recovery block.
// Assumes go is a one-cycle command; released pins float high (pull-up).
`timescale 1ns/1ps
`default_nettype none
module rue_fab_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [1:0] cmd,
  output var  logic       fabric_reconfig_request,
  output var  logic       ext_pin_n,
  output var  logic       stat_pin_n
);
  logic [5:0] cnt;
  logic [1:0] mode;
  initial begin
    cnt = 6'h00;
    mode = 2'h0;
  end
  always @(posedge clk) begin
    if (go) begin
      mode <= cmd;
      cnt <= 6'h20;
    end else if (cnt != 6'h00)
      cnt <= cnt - 6'h01;
  end
  // Held 32 cycles, 256 ns, to clear the minimum hold
  assign fabric_reconfig_request = mode == 2'h1 && cnt != 6'h00;
  // Short low pulse, then released
  assign ext_pin_n = !(mode == 2'h2 && cnt > 6'h1c);
  assign stat_pin_n = !(mode == 2'h3 && cnt > 6'h18);
endmodule // rue_fab_model
`default_nettype wire

//--- tb/rue_top_tb.sv
// Self-checking bench for the recovery block over AHB-Lite.
// Assumes the block answers with zero wait states; short counts set here.
`include "rue_map.vh"
`timescale 1ns/1ps
`default_nettype none
module rue_top_tb;
  logic        hclk, hresetn, hwrite, crc, done, go, hready, start, app;
  logic        fab, ext_n, stat_n;
  logic [1:0]  htrans, cmd;
  logic [23:0] page;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          miscompares, n_tests;
  rue_top #(.WD_PRESCALE(2), .RELOAD_CYC(2)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata),
    .config_status_pin_n(stat_n), .external_config_request_pin_n(ext_n),
    .fabric_reconfig_request(fab), .config_crc_error(crc),
    .config_done(done), .reconfig_start(start),
    .page_start_address(page), .app_user_mode(app));
  rue_fab_model fab_u (.clk(hclk), .go(go), .cmd(cmd),
    .fabric_reconfig_request(fab), .ext_pin_n(ext_n), .stat_pin_n(stat_n));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait, so a dead slave ends the run instead of hanging it
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      miscompares++;
      test_done;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic wait_start(input logic [23:0] p);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (start !== 1'b1 && n < 200);
    check({31'h0, start}, 32'h1);
    check({8'h00, page}, {8'h00, p});
    if (start !== 1'b1)
      test_done;
  endtask
  task automatic go_app(input logic wd, input logic run);
    ahb(1'b1, `RUE_OFS_APP_PAGE, 32'h00123456, r);
    ahb(1'b1, `RUE_OFS_CTRL, {30'h0, wd, 1'b1}, r);
    wait_start(24'h123456);
    if (run) begin
      done <= 1'b1;
      @(posedge hclk);
      done <= 1'b0;
      @(posedge hclk);
      check({31'h0, app}, 32'h1);
    end
  endtask
  task automatic pulse_crc;
    crc <= 1'b1;
    @(posedge hclk);
    crc <= 1'b0;
  endtask
  task automatic fab_cmd(input logic [1:0] c);
    cmd <= c;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
  endtask
  task automatic param_rd(input logic [2:0] s, input logic [23:0] v);
    logic saw;
    int   n;
    ahb(1'b1, `RUE_OFS_PARAM_CMD, {29'h0, s}, r);
    saw = 1'b0;
    n = 0;
    do begin
      ahb(1'b0, `RUE_OFS_PARAM_CMD, 32'h0, r);
      saw = saw | r[`RUE_PCMD_BUSY];
      n++;
    end while (r[`RUE_PCMD_BUSY] !== 1'b0 && n < 20);
    check({31'h0, saw}, 32'h1);
    check(r, {29'h0, s});
    if (r[`RUE_PCMD_BUSY] !== 1'b0)
      test_done;
    ahb(1'b0, `RUE_OFS_PARAM_DAT, 32'h0, r);
    check(r, {8'h0, v});
  endtask
  task automatic read_cause(input logic [4:0] c);
    param_rd(`RUE_PRM_SOURCE, {19'h0, c});
    ahb(1'b0, `RUE_OFS_STATUS, 32'h0, r);
    check(r, {21'h0, 3'h1, 3'h0, c});
  endtask
  task automatic s_crc;
    go_app(1'b0, 1'b0);
    pulse_crc;
    wait_start(24'h000000);
    read_cause(`RUE_CAUSE_CRC);
    param_rd(`RUE_PRM_APP_FLAG, 24'h000000);
  endtask
  task automatic s_user;
    go_app(1'b0, 1'b1);
    pulse_crc;
    repeat (8) @(posedge hclk);
    check({31'h0, app}, 32'h1);
    ahb(1'b0, `RUE_OFS_STATUS, 32'h0, r);
    check(r, {21'h0, 3'h4, 3'h0, `RUE_CAUSE_CRC});
    param_rd(`RUE_PRM_APP_FLAG, 24'h000001);
    param_rd(`RUE_PRM_WD_EN, 24'h000000);
    fab_cmd(2'h1);
    wait_start(24'h000000);
    read_cause(`RUE_CAUSE_FABRIC);
  endtask
  task automatic s_pins;
    go_app(1'b0, 1'b0);
    fab_cmd(2'h3);
    wait_start(24'h000000);
    read_cause(`RUE_CAUSE_STATUS);
    go_app(1'b0, 1'b1);
    fab_cmd(2'h2);
    wait_start(24'h000000);
    read_cause(`RUE_CAUSE_EXTCFG);
  endtask
  task automatic s_wdog;
    ahb(1'b1, `RUE_OFS_WD_TIME, 32'h3, r);
    go_app(1'b1, 1'b1);
    repeat (6) ahb(1'b1, `RUE_OFS_WD_KICK, 32'h0, r);
    check({31'h0, app}, 32'h1);
    ahb(1'b0, `RUE_OFS_CTRL, 32'h0, r);
    check(r, 32'h2);
    wait_start(24'h000000);
    read_cause(`RUE_CAUSE_WDOG);
    param_rd(`RUE_PRM_WD_TIME, 24'h000003);
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    {hresetn, hwrite, crc, done, go, htrans, cmd} = '0;
    {haddr, hwdata, r} = '0;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h40, 32'h0, r);
    check(r, 32'h0);
    s_crc;
    s_user;
    s_pins;
    s_wdog;
    test_done;
  end
endmodule // rue_top_tb
`default_nettype wire
